// ==== common/cnt_pkg.sv ====
package cnt_pkg;
   // Register byte addresses, one aligned word each
   localparam logic [7:0] OFS_DIR_CLK = 8'h00;
   localparam logic [7:0] OFS_RUN = 8'h04;
   localparam logic [7:0] OFS_SYS1 = 8'h08;
   localparam logic [7:0] OFS_DATA_L = 8'h0C;
   localparam logic [7:0] OFS_DATA_M = 8'h10;
   localparam logic [7:0] OFS_DATA_H = 8'h14;
   localparam logic [7:0] OFS_PWM_ROUTE = 8'h18;
   // Field positions
   localparam int DIR_UP_BIT = 3;
   localparam int RUN_START_BIT = 3;
   localparam int RUN_EVCNT_BIT = 2;
   localparam int RUN_ENCOMP_BIT = 1;
   localparam int RUN_LOAD_BIT = 0;
   localparam int SYS_GLOBAL_INTERRUPT_ENABLE_BIT = 3;
   localparam int SYS_SLEEP_BIT = 2;
   localparam int SYS_CMPW_BIT = 1;
   localparam int SYS_TEST_BIT = 0;
   localparam int PWM_ROUTE_BIT = 0;
   // Reset values
   localparam logic [3:0] RST_NIBBLE = 4'h0;
   localparam logic [9:0] RST_COUNT = 10'h000;
   localparam logic [1:0] RST_LEN = 2'h0;
   // Length masks for length_select codes 0..3
   localparam logic [9:0] MASK_10 = 10'h3FF;
   localparam logic [9:0] MASK_8 = 10'h0FF;
   localparam logic [9:0] MASK_6 = 10'h03F;
   localparam logic [9:0] MASK_4 = 10'h00F;
   // Prescaler taps for clock_source_select codes 1..6
   localparam int TAP_SEL1 = 15;
   localparam int TAP_SEL2 = 12;
   localparam int TAP_SEL3 = 10;
   localparam int TAP_SEL4 = 8;
   localparam int TAP_SEL5 = 4;
   localparam int TAP_SEL6 = 1;

   typedef enum logic [1:0] {SYNC_OFF, SYNC_WAIT, SYNC_RUN} sync_e;

   typedef struct packed {
      logic up;
      logic [2:0] clock_source_select;
      logic start;
      logic event_count_enable;
      logic en_comp;
   } ctl_s;

   typedef struct packed {
      logic global_interrupt_enable;
      logic sleep;
      logic compare_width_select;
      logic factory_test_bit;
   } sys_s;
endpackage : cnt_pkg

// ==== hdl/updown_counter_compare_pwm.sv ====
// Overview of operation
// RULE_01 Load bit copies preload value into count
// RULE_02 Load bit self-clears, always reads zero
// RULE_03 Count readable anytime via data nibbles
// RULE_04 Low nibble read captures bits 9:4 shadow
// RULE_05 Software stops counter before fast-clock reads
// RULE_06 Down mode: terminal request at zero
// RULE_07 Up mode: terminal request at all-ones
// RULE_08 Loading never raises any request
// RULE_09 Direction change inverts the count value
// RULE_10 Loading zero clears start, no request
// RULE_11 Software avoids forbidden compare values
// RULE_12 Software follows the seven-step setup order
// RULE_13 Software routes PWM during step five
// RULE_14 Clock select: PA0, taps 15..1, PA3
// RULE_15 Reset: source PA0, counting down
// RULE_16 Length select: 10, 8, 6, 4 bits
// RULE_17 Compare width select resets to limited
// RULE_18 Data nibbles hold preload/compare bits 9:0
// RULE_19 Compare request on match, only when enabled
// RULE_20 Load clears compare enable, restores PWM level
// RULE_21 PWM toggles on roll-over and compare match
// RULE_22 Cyclic counter, direction defaults to down
// RULE_23 Reduced length wraps within selected bits; count carries into the upper bits, only terminal, roll-over and limited compare are masked
`timescale 1ns/100ps
`default_nettype none
module updown_counter_compare_pwm (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Counting clock sources
   input wire logic port_a_bit0,
   input wire logic port_a_bit3,
   input wire logic [15:0] prescaler_tap,
   // Events and outputs
   output logic terminal_count_irq,
   output logic compare_match_irq,
   output logic pwm_out,
   output logic port_b_bit3,
   output logic pwm_routing_enable,
   output logic global_interrupt_enable,
   output logic sleep_request,
   output logic factory_test_bit
);
   cnt_pkg::ctl_s ctl_r;
   cnt_pkg::sys_s sys_r;
   cnt_pkg::sync_e sync_r;
   logic [9:0] preload_value_r;
   logic [9:0] count_r;
   logic [9:4] count_shadow_r;
   logic [1:0] length_select_r;
   logic pwm_routing_r;
   logic src_prev_r;
   logic pwm_r;
   logic tc_irq_r;
   logic cmp_irq_r;
   logic [31:0] prdata_r;
   logic slverr_r;
   logic src_sel;
   logic src_rise;
   logic src_fall;
   logic wr_en;
   logic rd_setup;
   logic load_wr;
   logic dir_wr;
   logic step;
   logic [9:0] len_mask;
   logic [9:0] count_nxt;
   logic term_hit;
   logic roll_over;
   logic cmp_lim;
   logic cmp_full;
   logic cmp_hit;
   logic mapped;

   // APB decode; writes act at the access edge, reads latch at setup
   assign wr_en = psel & penable & pwrite;
   assign rd_setup = psel & ~penable & ~pwrite;
   assign load_wr = wr_en & (paddr == cnt_pkg::OFS_RUN) & pwdata[cnt_pkg::RUN_LOAD_BIT];
   assign dir_wr = wr_en & (paddr == cnt_pkg::OFS_DIR_CLK);
   assign mapped = (paddr == cnt_pkg::OFS_DIR_CLK) | (paddr == cnt_pkg::OFS_RUN)
      | (paddr == cnt_pkg::OFS_SYS1) | (paddr == cnt_pkg::OFS_DATA_L)
      | (paddr == cnt_pkg::OFS_DATA_M) | (paddr == cnt_pkg::OFS_DATA_H)
      | (paddr == cnt_pkg::OFS_PWM_ROUTE);
   assign pready = psel & penable; // Zero wait states
   assign pslverr = psel & penable & slverr_r;
   assign prdata = prdata_r;

   // Clock source mux
   always_comb begin
      case (ctl_r.clock_source_select)
         3'h0: src_sel = port_a_bit0; // RULE_14
         3'h1: src_sel = prescaler_tap[cnt_pkg::TAP_SEL1];
         3'h2: src_sel = prescaler_tap[cnt_pkg::TAP_SEL2];
         3'h3: src_sel = prescaler_tap[cnt_pkg::TAP_SEL3];
         3'h4: src_sel = prescaler_tap[cnt_pkg::TAP_SEL4];
         3'h5: src_sel = prescaler_tap[cnt_pkg::TAP_SEL5];
         3'h6: src_sel = prescaler_tap[cnt_pkg::TAP_SEL6];
         default: src_sel = port_a_bit3;
      endcase
   end

   // Edge detect on the selected source; inputs already synchronous
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         src_prev_r <= 1'b0;
      end else begin
         src_prev_r <= src_sel;
      end
   end
   assign src_rise = src_sel & ~src_prev_r;
   assign src_fall = ~src_sel & src_prev_r;

   // Length mask
   always_comb begin
      case (length_select_r)
         2'h0: len_mask = cnt_pkg::MASK_10; // RULE_16
         2'h1: len_mask = cnt_pkg::MASK_8;
         2'h2: len_mask = cnt_pkg::MASK_6;
         default: len_mask = cnt_pkg::MASK_4;
      endcase
   end

   // Step and event terms; a load cycle never steps, so it raises nothing
   assign step = (sync_r == cnt_pkg::SYNC_RUN) & ctl_r.start & src_rise & ~load_wr; // RULE_08
   assign count_nxt = ctl_r.up ? count_r + 10'h001 : count_r - 10'h001; // RULE_22
   // Terminal looks only at the selected length bits
   assign term_hit = ctl_r.up ? ((count_nxt & len_mask) == len_mask) // RULE_07 RULE_23
                              : ((count_nxt & len_mask) == 10'h000); // RULE_06
   assign roll_over = ctl_r.up ? ((count_r & len_mask) == len_mask) // RULE_23
                               : ((count_r & len_mask) == 10'h000);
   assign cmp_lim = (count_nxt & len_mask) == (preload_value_r & len_mask);
   assign cmp_full = count_nxt == preload_value_r;
   assign cmp_hit = sys_r.compare_width_select ? cmp_full : cmp_lim;

   // Start synchronisation: wait for a falling edge unless event counting
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sync_r <= cnt_pkg::SYNC_OFF;
      end else begin
         case (sync_r)
            cnt_pkg::SYNC_OFF: begin
               if (ctl_r.start) begin
                  sync_r <= ctl_r.event_count_enable ? cnt_pkg::SYNC_RUN : cnt_pkg::SYNC_WAIT;
               end
            end
            cnt_pkg::SYNC_WAIT: begin
               if (!ctl_r.start) begin
                  sync_r <= cnt_pkg::SYNC_OFF;
               end else if (src_fall) begin
                  sync_r <= cnt_pkg::SYNC_RUN;
               end
            end
            cnt_pkg::SYNC_RUN: begin
               if (!ctl_r.start) begin
                  sync_r <= cnt_pkg::SYNC_OFF;
               end
            end
            default: sync_r <= cnt_pkg::SYNC_OFF;
         endcase
      end
   end

   // Control register; hardware clears take part in the same process
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctl_r <= '0; // RULE_15 RULE_22
      end else begin
         if (dir_wr) begin
            ctl_r.up <= pwdata[cnt_pkg::DIR_UP_BIT];
            ctl_r.clock_source_select <= pwdata[2:0]; // RULE_14
         end
         if (wr_en && paddr == cnt_pkg::OFS_RUN) begin
            ctl_r.start <= pwdata[cnt_pkg::RUN_START_BIT];
            ctl_r.event_count_enable <= pwdata[cnt_pkg::RUN_EVCNT_BIT];
            ctl_r.en_comp <= pwdata[cnt_pkg::RUN_ENCOMP_BIT];
         end
         if (load_wr) begin
            ctl_r.en_comp <= 1'b0; // RULE_20
            if (preload_value_r == 10'h000) begin
               ctl_r.start <= 1'b0; // RULE_10
            end
         end
         // Pulse train ends itself when routed with full compare
         if (step && ctl_r.en_comp && cmp_full && sys_r.compare_width_select
             && pwm_routing_r) begin
            ctl_r.start <= 1'b0;
         end
      end
   end

   // System and routing bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sys_r <= '0; // RULE_17
         pwm_routing_r <= 1'b0;
      end else begin
         if (wr_en && paddr == cnt_pkg::OFS_SYS1) begin
            sys_r <= pwdata[3:0];
         end
         if (wr_en && paddr == cnt_pkg::OFS_PWM_ROUTE) begin
            pwm_routing_r <= pwdata[cnt_pkg::PWM_ROUTE_BIT];
         end
      end
   end

   // Preload/compare nibbles and length select
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         preload_value_r <= cnt_pkg::RST_COUNT;
         length_select_r <= cnt_pkg::RST_LEN;
      end else if (wr_en) begin
         case (paddr)
            cnt_pkg::OFS_DATA_L: preload_value_r[3:0] <= pwdata[3:0]; // RULE_18
            cnt_pkg::OFS_DATA_M: preload_value_r[7:4] <= pwdata[3:0];
            cnt_pkg::OFS_DATA_H: begin
               preload_value_r[9:8] <= pwdata[1:0];
               length_select_r <= pwdata[3:2]; // RULE_16
            end
            default: ;
         endcase
      end
   end

   // Running count
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_r <= cnt_pkg::RST_COUNT;
      end else if (load_wr) begin
         count_r <= preload_value_r; // RULE_01
      end else if (dir_wr && (pwdata[cnt_pkg::DIR_UP_BIT] != ctl_r.up)) begin
         count_r <= ~count_r; // RULE_09
      end else if (step) begin
         count_r <= count_nxt; // RULE_22
      end
   end

   // Event pulses, one cycle after the counting step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tc_irq_r <= 1'b0;
         cmp_irq_r <= 1'b0;
      end else begin
         tc_irq_r <= step & term_hit; // RULE_06 RULE_07
         cmp_irq_r <= step & ctl_r.en_comp & cmp_hit; // RULE_19
      end
   end

   // PWM level; compare for PWM always uses the selected length
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pwm_r <= 1'b1;
      end else if (!ctl_r.en_comp) begin
         pwm_r <= ~ctl_r.up; // RULE_20
      end else if (step && (roll_over || cmp_lim)) begin
         pwm_r <= ~pwm_r; // RULE_21
      end
   end

   // Read path; a low nibble read also freezes bits 9:4
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         count_shadow_r <= 6'h00;
         prdata_r <= 32'h0000_0000;
         slverr_r <= 1'b0;
      end else if (psel && !penable) begin
         slverr_r <= ~mapped;
         prdata_r <= 32'h0000_0000;
         if (rd_setup) begin
            case (paddr)
               cnt_pkg::OFS_DIR_CLK: prdata_r[3:0] <= {ctl_r.up, ctl_r.clock_source_select};
               // Load reads as zero
               cnt_pkg::OFS_RUN: prdata_r[3:0] <= {ctl_r.start, ctl_r.event_count_enable,
                  ctl_r.en_comp, 1'b0}; // RULE_02
               cnt_pkg::OFS_SYS1: prdata_r[3:0] <= sys_r;
               cnt_pkg::OFS_DATA_L: begin
                  prdata_r[3:0] <= count_r[3:0]; // RULE_03
                  count_shadow_r <= count_r[9:4]; // RULE_04
               end
               cnt_pkg::OFS_DATA_M: prdata_r[3:0] <= count_shadow_r[7:4]; // RULE_04
               cnt_pkg::OFS_DATA_H: prdata_r[3:0] <= {length_select_r, count_shadow_r[9:8]};
               cnt_pkg::OFS_PWM_ROUTE: prdata_r[0] <= pwm_routing_r;
               default: ;
            endcase
         end
      end
   end

   // Outputs
   assign terminal_count_irq = tc_irq_r;
   assign compare_match_irq = cmp_irq_r;
   assign pwm_out = pwm_r;
   assign port_b_bit3 = pwm_routing_r & pwm_r; // RULE_21
   assign pwm_routing_enable = pwm_routing_r;
   assign global_interrupt_enable = sys_r.global_interrupt_enable;
   assign sleep_request = sys_r.sleep;
   assign factory_test_bit = sys_r.factory_test_bit;

   // Checks
   sequence s_load;
      load_wr;
   endsequence
   sequence s_pwm_restore;
      !ctl_r.en_comp ##1 (pwm_r == !ctl_r.up);
   endsequence

   property p_load_copy;
      @(posedge pclk) disable iff (!presetn) load_wr |=> count_r == $past(preload_value_r);
   endproperty
   a_load_copy: assert property (p_load_copy) else $error("load did not copy preload"); // RULE_01

   property p_load_reads_zero;
      @(posedge pclk) disable iff (!presetn)
         rd_setup && paddr == cnt_pkg::OFS_RUN |=> prdata_r[0] == 1'b0;
   endproperty
   a_load_reads_zero: assert property (p_load_reads_zero) else $error("load bit read one"); // RULE_02

   property p_shadow;
      @(posedge pclk) disable iff (!presetn)
         rd_setup && paddr == cnt_pkg::OFS_DATA_L |=> count_shadow_r == $past(count_r[9:4]);
   endproperty
   a_shadow: assert property (p_shadow) else $error("shadow not captured"); // RULE_04

   property p_tc_down;
      @(posedge pclk) disable iff (!presetn)
         step && !ctl_r.up && (count_nxt & len_mask) == 10'h000 |=> terminal_count_irq;
   endproperty
   a_tc_down: assert property (p_tc_down) else $error("no terminal at zero"); // RULE_06

   property p_tc_up;
      @(posedge pclk) disable iff (!presetn)
         terminal_count_irq && $past(ctl_r.up) |-> (count_r & len_mask) == len_mask;
   endproperty
   a_tc_up: assert property (p_tc_up) else $error("terminal not at all-ones"); // RULE_07

   property p_no_irq_on_load;
      @(posedge pclk) disable iff (!presetn)
         s_load |=> !terminal_count_irq && !compare_match_irq;
   endproperty
   a_no_irq_on_load: assert property (p_no_irq_on_load) else $error("request on load"); // RULE_08

   property p_dir_invert;
      @(posedge pclk) disable iff (!presetn)
         dir_wr && pwdata[cnt_pkg::DIR_UP_BIT] != ctl_r.up |=> count_r == ~$past(count_r);
   endproperty
   a_dir_invert: assert property (p_dir_invert) else $error("count not inverted"); // RULE_09

   property p_zero_stop;
      @(posedge pclk) disable iff (!presetn)
         load_wr && preload_value_r == 10'h000 |=> !ctl_r.start ##1 !terminal_count_irq;
   endproperty
   a_zero_stop: assert property (p_zero_stop) else $error("zero load did not stop"); // RULE_10

   property p_cmp_gated;
      @(posedge pclk) disable iff (!presetn) compare_match_irq |-> $past(ctl_r.en_comp);
   endproperty
   a_cmp_gated: assert property (p_cmp_gated) else $error("compare while disabled"); // RULE_19

   property p_load_restore;
      @(posedge pclk) disable iff (!presetn) s_load |=> s_pwm_restore;
   endproperty
   a_load_restore: assert property (p_load_restore) else $error("pwm start level lost"); // RULE_20

   property p_pwm_toggle;
      @(posedge pclk) disable iff (!presetn)
         $changed(pwm_r) && $past(ctl_r.en_comp) |-> $past(step);
   endproperty
   a_pwm_toggle: assert property (p_pwm_toggle) else $error("pwm moved without step"); // RULE_21
endmodule : updown_counter_compare_pwm
`default_nettype wire

// ==== test/tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // Bench drive, all changed just after a rising edge
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [7:0] src = 8'h00;
   logic [15:0] tap;
   // Design outputs
   wire logic [31:0] prdata;
   wire logic pready, pslverr, term_irq, cmp_irq, pwm_out, port_b_bit3;
   wire logic pwm_routing_enable, global_interrupt_enable, sleep_request, factory_test_bit;
   // Bookkeeping
   int errors = 0;
   int n_compared = 0;
   int n_term = 0;
   int n_cmp = 0;
   int cycles = 0;
   logic [15:0] lfsr = 16'hCE45;
   logic [32:0] exp_q[$];
   logic [9:0] v;

   updown_counter_compare_pwm dut_u (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .port_a_bit0(src[0]), .port_a_bit3(src[7]),
      .prescaler_tap(tap), .terminal_count_irq(term_irq), .compare_match_irq(cmp_irq),
      .pwm_out(pwm_out), .port_b_bit3(port_b_bit3), .pwm_routing_enable(pwm_routing_enable),
      .global_interrupt_enable(global_interrupt_enable), .sleep_request(sleep_request),
      .factory_test_bit(factory_test_bit));

   // Source vector mapped onto the used prescaler taps, rest held low
   always_comb begin
      tap = 16'h0000;
      tap[cnt_pkg::TAP_SEL1] = src[1];
      tap[cnt_pkg::TAP_SEL2] = src[2];
      tap[cnt_pkg::TAP_SEL3] = src[3];
      tap[cnt_pkg::TAP_SEL4] = src[4];
      tap[cnt_pkg::TAP_SEL5] = src[5];
      tap[cnt_pkg::TAP_SEL6] = src[6];
   end

   // Free-running bus clock
   initial begin
      forever #2 pclk = ~pclk;
   end

   function automatic logic [15:0] lfsr_next(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr_next

   task automatic end_of_test();
      $display("compared %0d, mismatches %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk

   // One APB transfer; waits on pready, never a fixed count
   task automatic apb(input logic w, input logic [7:0] a, input logic [3:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {28'h0000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [3:0] d);
      apb(1'b1, a, d);
   endtask : wr

   // Expected read noted first, compared by the monitor
   task automatic rd(input logic [7:0] a, input logic [3:0] e);
      exp_q.push_back({1'b0, 28'h0000000, e});
      apb(1'b0, a, 4'h0);
   endtask : rd

   // Rising edges on the sources in mask m, slow against pclk
   task automatic tick(input logic [7:0] m, input int n);
      repeat (n) begin
         @(posedge pclk);
         src <= m;
         @(posedge pclk);
         src <= 8'h00;
         @(posedge pclk);
      end
      repeat (2) @(posedge pclk);
   endtask : tick

   // Monitor: read results and one-cycle request pulses
   always @(posedge pclk) begin
      if (psel && penable && pready === 1'b1 && !pwrite) begin
         if (exp_q.size() == 0) begin
            chk({pslverr, prdata}, 33'h1FFFFFFFF);
         end else begin
            chk({pslverr, prdata}, exp_q.pop_front());
         end
      end
      if (term_irq === 1'b1) n_term++;
      if (cmp_irq === 1'b1) n_cmp++;
   end

   // Hang guard, generous against a run of a few hundred cycles
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         errors++;
         $display("MISMATCH at %0t: timeout", $time);
         end_of_test();
      end
   end

   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      // Reset values, unmapped place
      for (int i = 0; i < 7; i++) rd(8'(i * 4), 4'h0);
      exp_q.push_back({1'b1, 32'h00000000});
      apb(1'b0, 8'h1C, 4'h0);
      #1;
      chk({32'h0, pwm_out}, 33'h1);
      chk({31'h0, port_b_bit3, pwm_routing_enable}, 33'h0);
      lfsr = lfsr_next(lfsr);
      wr(cnt_pkg::OFS_SYS1, lfsr[3:0]);
      rd(cnt_pkg::OFS_SYS1, lfsr[3:0]);
      #1;
      chk({30'h0, global_interrupt_enable, sleep_request, factory_test_bit},
         {30'h0, lfsr[3], lfsr[2], lfsr[0]});
      wr(cnt_pkg::OFS_SYS1, 4'h0);
      $display("test 1 done");
      // Load of a random preload, then read back in low-first order
      lfsr = lfsr_next(lfsr);
      v = lfsr[9:0];
      wr(cnt_pkg::OFS_DATA_L, v[3:0]);
      wr(cnt_pkg::OFS_DATA_M, v[7:4]);
      wr(cnt_pkg::OFS_DATA_H, {2'b00, v[9:8]});
      wr(cnt_pkg::OFS_RUN, 4'h1);
      rd(cnt_pkg::OFS_RUN, 4'h0);
      rd(cnt_pkg::OFS_DATA_L, v[3:0]);
      rd(cnt_pkg::OFS_DATA_M, v[7:4]);
      rd(cnt_pkg::OFS_DATA_H, {2'b00, v[9:8]});
      chk({1'b0, 32'(n_term + n_cmp)}, 33'h0);
      // Direction change inverts, a repeated same value does not
      wr(cnt_pkg::OFS_DIR_CLK, 4'h8);
      rd(cnt_pkg::OFS_DATA_L, ~v[3:0]);
      rd(cnt_pkg::OFS_DATA_M, ~v[7:4]);
      rd(cnt_pkg::OFS_DATA_H, {2'b00, ~v[9:8]});
      wr(cnt_pkg::OFS_DIR_CLK, 4'h8);
      rd(cnt_pkg::OFS_DATA_L, ~v[3:0]);
      $display("test 2 done");
      // Up count in 4-bit length from D: terminal at F, wrap carries upward
      wr(cnt_pkg::OFS_DIR_CLK, 4'h9);
      wr(cnt_pkg::OFS_DATA_L, 4'hD);
      wr(cnt_pkg::OFS_DATA_M, 4'h0);
      wr(cnt_pkg::OFS_DATA_H, 4'hC);
      wr(cnt_pkg::OFS_RUN, 4'h1);
      wr(cnt_pkg::OFS_RUN, 4'hC);
      tick(8'h02, 2);
      chk({1'b0, 32'(n_term)}, 33'h1);
      tick(8'h02, 1);
      // Stopped before the low nibble read, as software must for fast sources
      wr(cnt_pkg::OFS_RUN, 4'h0);
      rd(cnt_pkg::OFS_DATA_L, 4'h0);
      rd(cnt_pkg::OFS_DATA_M, 4'h1);
      rd(cnt_pkg::OFS_DATA_H, 4'hC);
      chk({1'b0, 32'(n_term)}, 33'h1);
      $display("test 3 done");
      // Down count from 2 reaches zero
      wr(cnt_pkg::OFS_RUN, 4'h0);
      wr(cnt_pkg::OFS_DIR_CLK, 4'h1);
      wr(cnt_pkg::OFS_DATA_L, 4'h2);
      wr(cnt_pkg::OFS_DATA_H, 4'h0);
      wr(cnt_pkg::OFS_RUN, 4'hD);
      rd(cnt_pkg::OFS_RUN, 4'hC);
      tick(8'h02, 2);
      chk({1'b0, 32'(n_term)}, 33'h2);
      rd(cnt_pkg::OFS_DATA_L, 4'h0);
      // Loading zero stops, with no request
      wr(cnt_pkg::OFS_DATA_L, 4'h0);
      wr(cnt_pkg::OFS_RUN, 4'hD);
      rd(cnt_pkg::OFS_RUN, 4'h4);
      chk({1'b0, 32'(n_term + n_cmp)}, 33'h2);
      $display("test 4 done");
      // PWM with limited compare at 2, 4-bit length, routed out
      wr(cnt_pkg::OFS_DIR_CLK, 4'h9);
      wr(cnt_pkg::OFS_DATA_H, 4'hC);
      wr(cnt_pkg::OFS_RUN, 4'h1);
      @(posedge pclk);
      #1;
      chk({32'h0, pwm_out}, 33'h0);
      wr(cnt_pkg::OFS_PWM_ROUTE, 4'h1);
      wr(cnt_pkg::OFS_DATA_L, 4'h2);
      wr(cnt_pkg::OFS_RUN, 4'hE);
      tick(8'h02, 3);
      chk({1'b0, 32'(n_cmp)}, 33'h1);
      chk({30'h0, pwm_out, port_b_bit3, pwm_routing_enable}, 33'h7);
      tick(8'h02, 13);
      chk({31'h0, pwm_out, port_b_bit3}, 33'h0);
      chk({1'b0, 32'(n_term + n_cmp)}, 33'h4);
      // A load clears compare enable; no match seen afterwards
      wr(cnt_pkg::OFS_RUN, 4'hB);
      rd(cnt_pkg::OFS_RUN, 4'h8);
      tick(8'h02, 4);
      chk({1'b0, 32'(n_cmp)}, 33'h1);
      $display("test 5 done");
      // Full compare with routing ends the pulse train at the match
      wr(cnt_pkg::OFS_RUN, 4'h0);
      wr(cnt_pkg::OFS_DATA_L, 4'h0);
      wr(cnt_pkg::OFS_RUN, 4'h1);
      wr(cnt_pkg::OFS_SYS1, 4'h2);
      rd(cnt_pkg::OFS_SYS1, 4'h2);
      wr(cnt_pkg::OFS_DATA_M, 4'h1);
      wr(cnt_pkg::OFS_DATA_L, 4'h2);
      wr(cnt_pkg::OFS_RUN, 4'hE);
      tick(8'h02, 20);
      chk({1'b0, 32'(n_cmp)}, 33'h2);
      chk({1'b0, 32'(n_term)}, 33'h4);
      chk({31'h0, pwm_out, port_b_bit3}, 33'h3);
      rd(cnt_pkg::OFS_RUN, 4'h6);
      rd(cnt_pkg::OFS_DATA_L, 4'h2);
      // A load while comparing puts the start level back
      wr(cnt_pkg::OFS_RUN, 4'h1);
      @(posedge pclk);
      #1;
      chk({31'h0, pwm_out, port_b_bit3}, 33'h0);
      $display("test 6 done");
      // Every clock source code; other sources must not step
      for (int c = 0; c < 8; c++) begin
         wr(cnt_pkg::OFS_RUN, 4'h0);
         wr(cnt_pkg::OFS_DIR_CLK, 4'(8 + c));
         wr(cnt_pkg::OFS_DATA_L, 4'h1);
         wr(cnt_pkg::OFS_DATA_H, 4'(c << 2));
         wr(cnt_pkg::OFS_RUN, 4'h1);
         wr(cnt_pkg::OFS_RUN, 4'hC);
         tick(~(8'h01 << c), 1);
         tick(8'h01 << c, 1);
         rd(cnt_pkg::OFS_DATA_L, 4'h2);
         rd(cnt_pkg::OFS_DATA_H, 4'(c << 2));
      end
      $display("test 7 done");
      repeat (3) @(posedge pclk);
      chk({1'b0, 32'(exp_q.size())}, 33'h0);
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
